/* File: design/msd_params.svh */
/*
  address map, field positions, reset values and opcode constants for the
  memory space decoder. assumes it is included by bare name by every file
  that needs them.
*/
`ifndef MSD_PARAMS_SVH
`define MSD_PARAMS_SVH

// ==========================================================================
// special function register locations
`define MSD_ADDR_PAGE_SEL    8'h92
`define MSD_ADDR_PTR_LOW     8'h82
`define MSD_ADDR_PTR_HIGH    8'h83
`define MSD_SFR_BASE         8'h80

// ==========================================================================
// code_page_select fields and reset value
`define MSD_BIT_OPCODE_PAGE  0
`define MSD_BIT_LOOKUP_LOW   1
`define MSD_BIT_LOOKUP_HIGH  2
`define MSD_BIT_XRAM_EN      3
`define MSD_PAGE_SEL_RESET   8'h08

// ==========================================================================
// data ram, scratchpad and bit space
`define MSD_XRAM_LAST        16'h1FFF
`define MSD_BIT_BYTE_BASE    8'h20
`define MSD_NIBBLE_ZERO      4'h0
`define MSD_NIBBLE_EIGHT     4'h8
`define MSD_PTR_RESET        16'h0000

// ==========================================================================
// instruction decode
`define MSD_OP_PTR_DEC       8'hA5

`endif

/* File: design/msd_pkg.sv */
/*
  types shared by the memory space decoder and its bench.
  assumes msd_params.svh sits beside it.
*/
package msd_pkg;

  // ========================================================================
  // internal data memory access kinds
  typedef enum logic [1:0] {
    MSD_ACC_DIRECT,
    MSD_ACC_INDIRECT,
    MSD_ACC_WORK_REG,
    MSD_ACC_BIT
  } msd_acc_kind_t;

  // ========================================================================
  // request from the core for scratchpad, register or bit space
  typedef struct packed {
    logic          valid;
    logic          wr;
    msd_acc_kind_t kind;
    logic [7:0]    addr;
    logic [7:0]    wdata;
  } msd_iram_req_t;

  // ========================================================================
  // registered routing result
  typedef struct packed {
    logic       scratch_sel;
    logic       sfr_sel;
    logic       bit_mode;
    logic       wr;
    logic [7:0] addr;
    logic [2:0] bit_pos;
  } msd_iram_route_t;

endpackage

/* File: design/msd_decoder.sv */
/*
  memory space decoder for an 8-bit controller core: program page
  selection, data ram window, scratchpad / special register routing, bit
  space mapping and the data pointer with its decrement opcode.
  assumes the core presents at most one internal access per cycle; a fetch
  beats a table read in the same cycle. all synchronous to clk_sys.
*/
`timescale 1ns/1ns
`include "msd_params.svh"

module msd_decoder #(
  parameter int PAGE_ADDR_W = 16,
  parameter int PAGE_NUM_W  = 2,
  parameter int XRAM_ADDR_W = 13
) (
  input  wire logic                           clk_sys,
  input  wire logic                           sys_rst,
  // program memory requests
  input  wire logic                           fetch_req,
  input  wire logic [PAGE_ADDR_W-1:0]         fetch_addr,
  input  wire logic                           table_req,
  input  wire logic [PAGE_ADDR_W-1:0]         table_addr,
  output logic                                prog_rd_q,
  output logic                                prog_is_fetch_q,
  output logic [PAGE_NUM_W+PAGE_ADDR_W-1:0]   prog_addr_q,
  // data-space move
  input  wire logic                           move_req,
  input  wire logic                           move_wr,
  input  wire logic                           move_use_ptr,
  input  wire logic [15:0]                    move_addr,
  output logic                                xram_sel_q,
  output logic                                xram_wr_q,
  output logic [XRAM_ADDR_W-1:0]              xram_addr_q,
  output logic                                ext_sel_q,
  output logic [15:0]                         ext_addr_q,
  // scratchpad, working registers, bit space, special registers
  input  wire msd_pkg::msd_iram_req_t         iram_req,
  input  wire logic [1:0]                     reg_bank,
  output msd_pkg::msd_iram_route_t            iram_route_q,
  output logic                                own_hit_q,
  output logic [7:0]                          own_rdata_q,
  // instruction decode
  input  wire logic                           op_valid,
  input  wire logic [7:0]                     opcode,
  output logic [15:0]                         data_pointer,
  output logic [7:0]                          code_page_select
);

  // ========================================================================
  // software registers
  logic [7:0]  page_q;
  logic [7:0]  page_d;
  logic [15:0] ptr_q;
  logic [15:0] ptr_d;
  logic        sfr_wr_hit;

  // a byte write is only ours on a direct access above 7fh
  assign sfr_wr_hit = iram_req.valid && iram_req.wr
                      && iram_req.kind == msd_pkg::MSD_ACC_DIRECT
                      && iram_req.addr[7];

  always_comb begin
    page_d = page_q;
    ptr_d  = ptr_q;
    if (sfr_wr_hit && iram_req.addr == `MSD_ADDR_PAGE_SEL) begin
      page_d = iram_req.wdata;
    end
    // software writes win over the decrement so a reload is never lost
    if (sfr_wr_hit && iram_req.addr == `MSD_ADDR_PTR_LOW) begin
      ptr_d[7:0] = iram_req.wdata;
    end else if (sfr_wr_hit && iram_req.addr == `MSD_ADDR_PTR_HIGH) begin
      ptr_d[15:8] = iram_req.wdata;
    end else if (op_valid && opcode == `MSD_OP_PTR_DEC) begin
      ptr_d = ptr_q - 16'h0001;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      page_q <= `MSD_PAGE_SEL_RESET;
      ptr_q  <= `MSD_PTR_RESET;
    end else begin
      page_q <= page_d;
      ptr_q  <= ptr_d;
    end
  end

  assign data_pointer     = ptr_q;
  assign code_page_select = page_q;

  // ========================================================================
  // program memory page selection
  logic                                prog_rd_d;
  logic                                prog_is_fetch_d;
  logic [PAGE_NUM_W+PAGE_ADDR_W-1:0]   prog_addr_d;

  always_comb begin
    prog_rd_d       = fetch_req || table_req;
    prog_is_fetch_d = fetch_req;
    prog_addr_d     = prog_addr_q;
    if (fetch_req) begin
      // only pages 0 and 1 ever hold code
      prog_addr_d = {1'b0, page_q[`MSD_BIT_OPCODE_PAGE], fetch_addr};
    end else if (table_req) begin
      prog_addr_d = {page_q[`MSD_BIT_LOOKUP_HIGH],
                     page_q[`MSD_BIT_LOOKUP_LOW], table_addr};
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      prog_rd_q       <= 1'b0;
      prog_is_fetch_q <= 1'b0;
      prog_addr_q     <= '0;
    end else begin
      prog_rd_q       <= prog_rd_d;
      prog_is_fetch_q <= prog_is_fetch_d;
      prog_addr_q     <= prog_addr_d;
    end
  end

  // ========================================================================
  // data-space move window
  logic [15:0]            move_ea;
  logic                   in_window;
  logic                   xram_sel_d;
  logic                   ext_sel_d;
  logic                   xram_wr_d;
  logic [XRAM_ADDR_W-1:0] xram_addr_d;
  logic [15:0]            ext_addr_d;

  assign move_ea   = move_use_ptr ? ptr_q : move_addr;
  assign in_window = move_ea <= `MSD_XRAM_LAST;

  always_comb begin
    xram_sel_d  = move_req && in_window && page_q[`MSD_BIT_XRAM_EN];
    ext_sel_d   = move_req && !xram_sel_d;
    xram_wr_d   = move_req && move_wr;
    xram_addr_d = move_ea[XRAM_ADDR_W-1:0];
    ext_addr_d  = move_ea;
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      xram_sel_q  <= 1'b0;
      ext_sel_q   <= 1'b0;
      xram_wr_q   <= 1'b0;
      xram_addr_q <= '0;
      ext_addr_q  <= 16'h0000;
    end else begin
      xram_sel_q  <= xram_sel_d;
      ext_sel_q   <= ext_sel_d;
      xram_wr_q   <= xram_wr_d;
      xram_addr_q <= xram_addr_d;
      ext_addr_q  <= ext_addr_d;
    end
  end

  // ========================================================================
  // scratchpad / special register routing
  // the data ram is never a target here: separate instruction, separate port
  msd_pkg::msd_iram_route_t route_d;
  logic                     own_hit_d;
  logic [7:0]               own_rdata_d;

  always_comb begin
    route_d     = '0;
    own_hit_d   = 1'b0;
    own_rdata_d = 8'h00;
    if (iram_req.valid) begin
      // the write flag rides only with a live request, so an idle route reads all zero
      route_d.wr = iram_req.wr;
      case (iram_req.kind)
        msd_pkg::MSD_ACC_DIRECT: begin
          route_d.addr        = iram_req.addr;
          route_d.sfr_sel     = iram_req.addr[7];
          route_d.scratch_sel = !iram_req.addr[7];
        end
        msd_pkg::MSD_ACC_INDIRECT: begin
          route_d.addr        = iram_req.addr;
          route_d.scratch_sel = 1'b1;
        end
        msd_pkg::MSD_ACC_WORK_REG: begin
          route_d.addr        = {3'b000, reg_bank, iram_req.addr[2:0]};
          route_d.scratch_sel = 1'b1;
        end
        msd_pkg::MSD_ACC_BIT: begin
          route_d.bit_mode = 1'b1;
          route_d.bit_pos  = iram_req.addr[2:0];
          if (iram_req.addr[7]) begin
            // bit space above 7fh only reaches bytes ending in 0 or 8
            route_d.addr    = {iram_req.addr[7:3], 3'b000};
            route_d.sfr_sel = 1'b1;
          end else begin
            route_d.addr        = `MSD_BIT_BYTE_BASE
                                  + {4'h0, iram_req.addr[6:3]};
            route_d.scratch_sel = 1'b1;
          end
        end
        default: begin
          route_d = '0;
        end
      endcase
      // own registers answer reads; unassigned addresses just read zero
      if (route_d.sfr_sel && !route_d.bit_mode) begin
        case (iram_req.addr)
          `MSD_ADDR_PAGE_SEL: begin
            own_hit_d   = 1'b1;
            own_rdata_d = page_q;
          end
          `MSD_ADDR_PTR_LOW: begin
            own_hit_d   = 1'b1;
            own_rdata_d = ptr_q[7:0];
          end
          `MSD_ADDR_PTR_HIGH: begin
            own_hit_d   = 1'b1;
            own_rdata_d = ptr_q[15:8];
          end
          default: begin
            own_hit_d   = 1'b0;
            own_rdata_d = 8'h00;
          end
        endcase
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      iram_route_q <= '0;
      own_hit_q    <= 1'b0;
      own_rdata_q  <= 8'h00;
    end else begin
      iram_route_q <= route_d;
      own_hit_q    <= own_hit_d;
      own_rdata_q  <= own_rdata_d;
    end
  end

  // ========================================================================
  // checks
  property p_fetch_page;
    @(posedge clk_sys) disable iff (sys_rst)
      fetch_req |=> prog_rd_q && prog_is_fetch_q
        && prog_addr_q == {1'b0, $past(page_q[`MSD_BIT_OPCODE_PAGE]), $past(fetch_addr)};
  endproperty
  a_fetch_page: assert property (p_fetch_page) else $error("bad fetch page");

  property p_code_low_half;
    @(posedge clk_sys) disable iff (sys_rst)
      prog_is_fetch_q |-> !prog_addr_q[PAGE_NUM_W+PAGE_ADDR_W-1];
  endproperty
  a_code_low_half: assert property (p_code_low_half) else $error("code above 128k");

  property p_table_page;
    @(posedge clk_sys) disable iff (sys_rst)
      (table_req && !fetch_req) |=> prog_addr_q[PAGE_NUM_W+PAGE_ADDR_W-1 -: 2]
        == {$past(page_q[`MSD_BIT_LOOKUP_HIGH]), $past(page_q[`MSD_BIT_LOOKUP_LOW])};
  endproperty
  a_table_page: assert property (p_table_page) else $error("bad table page");

  property p_xram_window;
    @(posedge clk_sys) disable iff (sys_rst)
      (move_req && in_window && page_q[`MSD_BIT_XRAM_EN])
        |=> xram_sel_q && !ext_sel_q && xram_addr_q == $past(move_ea[XRAM_ADDR_W-1:0]);
  endproperty
  a_xram_window: assert property (p_xram_window) else $error("data ram missed");

  property p_xram_disabled;
    @(posedge clk_sys) disable iff (sys_rst)
      (move_req && !page_q[`MSD_BIT_XRAM_EN]) |=> ext_sel_q && !xram_sel_q;
  endproperty
  a_xram_disabled: assert property (p_xram_disabled) else $error("disabled ram hit");

  property p_indirect_high;
    @(posedge clk_sys) disable iff (sys_rst)
      (iram_req.valid && iram_req.kind == msd_pkg::MSD_ACC_INDIRECT)
        |=> iram_route_q.scratch_sel && !iram_route_q.sfr_sel;
  endproperty
  a_indirect_high: assert property (p_indirect_high) else $error("indirect to sfr");

  property p_route_idle;
    @(posedge clk_sys) disable iff (sys_rst)
      !iram_req.valid |=> iram_route_q == '0;
  endproperty
  a_route_idle: assert property (p_route_idle) else $error("route not idle");

  property p_sfr_bit_nibble;
    @(posedge clk_sys) disable iff (sys_rst)
      (iram_route_q.sfr_sel && iram_route_q.bit_mode)
        |-> iram_route_q.addr[3:0] == `MSD_NIBBLE_ZERO
            || iram_route_q.addr[3:0] == `MSD_NIBBLE_EIGHT;
  endproperty
  a_sfr_bit_nibble: assert property (p_sfr_bit_nibble) else $error("bad bit byte");

  property p_bit_low_map;
    @(posedge clk_sys) disable iff (sys_rst)
      (iram_req.valid && iram_req.kind == msd_pkg::MSD_ACC_BIT && !iram_req.addr[7])
        |=> iram_route_q.scratch_sel && iram_route_q.addr[7:4] == 4'h2
            && iram_route_q.bit_pos == $past(iram_req.addr[2:0]);
  endproperty
  a_bit_low_map: assert property (p_bit_low_map) else $error("bit map wrong");

  property p_bank_map;
    @(posedge clk_sys) disable iff (sys_rst)
      (iram_req.valid && iram_req.kind == msd_pkg::MSD_ACC_WORK_REG)
        |=> iram_route_q.addr == {3'b000, $past(reg_bank), $past(iram_req.addr[2:0])};
  endproperty
  a_bank_map: assert property (p_bank_map) else $error("bank map wrong");

  property p_ptr_dec;
    @(posedge clk_sys) disable iff (sys_rst)
      (op_valid && opcode == `MSD_OP_PTR_DEC && !sfr_wr_hit)
        |=> data_pointer == $past(data_pointer) - 16'h0001;
  endproperty
  a_ptr_dec: assert property (p_ptr_dec) else $error("pointer not decremented");

endmodule // msd_decoder

/* File: verification/msd_core_model.sv */
/*
  core side of the memory space decoder: program, move, internal access
  and opcode requests. assumes the bench calls one task at a time.
*/
`timescale 1ns/1ns
// ==========================================================================
// request driver
module msd_core_model (
  input  wire logic              clk_sys,
  output logic                   fetch_req,
  output logic [15:0]            fetch_addr,
  output logic                   table_req,
  output logic [15:0]            table_addr,
  output logic                   move_req,
  output logic                   move_wr,
  output logic                   move_use_ptr,
  output logic [15:0]            move_addr,
  output msd_pkg::msd_iram_req_t iram_req,
  output logic [1:0]             reg_bank,
  output logic                   op_valid,
  output logic [7:0]             opcode
);
  initial begin
    {fetch_req, table_req, move_req, move_wr, move_use_ptr, op_valid} = 6'h00;
    {fetch_addr, table_addr, move_addr} = 48'h0000_0000_0000;
    iram_req = '0;
    reg_bank = 2'h0;
    opcode = 8'h00;
  end

  // one cycle per request, then release
  task automatic idle;
    @(negedge clk_sys);
    {fetch_req, table_req, move_req, op_valid} = 4'h0;
    iram_req.valid = 1'b0;
    // released lines show junk so a stale value never passes for a live one
    {fetch_addr, table_addr, move_addr} = ~{fetch_addr, table_addr, move_addr};
    iram_req.addr = ~iram_req.addr;
    opcode = ~opcode;
  endtask

  task automatic prog(input logic f, input logic t, input logic [15:0] a);
    @(negedge clk_sys);
    fetch_req = f;
    table_req = t;
    fetch_addr = f ? a : ~a;
    table_addr = f ? ~a : a;
    idle();
  endtask

  task automatic move(input logic wr, input logic p, input logic [15:0] a);
    @(negedge clk_sys);
    move_req = 1'b1;
    move_wr = wr;
    move_use_ptr = p;
    move_addr = a;
    idle();
  endtask

  // the core reads and writes any place here; unassigned ones read back empty
  task automatic iram(input logic wr, input msd_pkg::msd_acc_kind_t k,
                      input logic [7:0] a, input logic [7:0] d, input logic [1:0] b);
    @(negedge clk_sys);
    iram_req = {1'b1, wr, k, a, d};
    reg_bank = b;
    idle();
  endtask

  task automatic op(input logic [7:0] c);
    @(negedge clk_sys);
    op_valid = 1'b1;
    opcode = c;
    idle();
  endtask
endmodule // msd_core_model

/* File: verification/tb_memory_space_decoder.sv */
/*
  self-checking bench for the memory space decoder.
  assumes msd_pkg, msd_params.svh and msd_core_model are compiled first.
*/
`timescale 1ns/1ns
`include "msd_params.svh"
module tb_memory_space_decoder;
  logic                     clk_sys, sys_rst, fetch_req, table_req, op_valid;
  logic                     move_req, move_wr, move_use_ptr, prog_rd_q, prog_is_fetch_q;
  logic                     xram_sel_q, xram_wr_q, ext_sel_q, own_hit_q;
  logic [15:0]              fetch_addr, table_addr, move_addr, ext_addr_q, data_pointer;
  logic [17:0]              prog_addr_q;
  logic [12:0]              xram_addr_q;
  logic [7:0]               opcode, own_rdata_q, code_page_select;
  logic [1:0]               reg_bank;
  msd_pkg::msd_iram_req_t   iram_req;
  msd_pkg::msd_iram_route_t iram_route_q;
  int                       num_errors;
  int                       samples_checked;

  msd_decoder msd_decoder_inst (.clk_sys, .sys_rst, .fetch_req, .fetch_addr, .table_req,
    .table_addr, .prog_rd_q, .prog_is_fetch_q, .prog_addr_q, .move_req, .move_wr,
    .move_use_ptr, .move_addr, .xram_sel_q, .xram_wr_q, .xram_addr_q, .ext_sel_q,
    .ext_addr_q, .iram_req, .reg_bank, .iram_route_q, .own_hit_q, .own_rdata_q,
    .op_valid, .opcode, .data_pointer, .code_page_select);
  msd_core_model msd_core_model_inst (.clk_sys, .fetch_req, .fetch_addr, .table_req,
    .table_addr, .move_req, .move_wr, .move_use_ptr, .move_addr, .iram_req, .reg_bank,
    .op_valid, .opcode);

  // ========================================================================
  // helpers
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic wsfr(input logic [7:0] a, input logic [7:0] d);
    msd_core_model_inst.iram(1'b1, msd_pkg::MSD_ACC_DIRECT, a, d, 2'h0);
  endtask

  // bit position only matters for bit accesses
  task automatic rt(input msd_pkg::msd_acc_kind_t k, input logic [7:0] a,
                    input logic [1:0] b, input logic [14:0] e);
    msd_core_model_inst.iram(1'b0, k, a, 8'h00, b);
    if (k == msd_pkg::MSD_ACC_BIT)
      chk(iram_route_q, e);
    else
      chk(iram_route_q[14:3], e[14:3]);
  endtask

  // ========================================================================
  // scenarios
  task automatic t_reset;
    sys_rst = 1'b1;
    repeat (5) @(negedge clk_sys);
    sys_rst = 1'b0;
    chk(code_page_select, `MSD_PAGE_SEL_RESET);
    chk(data_pointer, `MSD_PTR_RESET);
    chk({prog_rd_q, xram_sel_q, ext_sel_q, iram_route_q}, 32'h0000_0000);
  endtask

  task automatic t_fetch;
    for (int pg = 0; pg < 2; pg++) begin
      wsfr(`MSD_ADDR_PAGE_SEL, 8'h0E | 8'(pg));
      msd_core_model_inst.prog(1'b1, 1'b0, 16'hFFFF);
      chk({prog_rd_q, prog_is_fetch_q, prog_addr_q}, {2'b11, 2'(pg), 16'hFFFF});
    end
  endtask

  task automatic t_table;
    for (int p = 0; p < 4; p++) begin
      wsfr(`MSD_ADDR_PAGE_SEL, 8'h09 | 8'(p << 1));
      msd_core_model_inst.prog(1'b0, 1'b1, 16'h1234);
      chk({prog_rd_q, prog_is_fetch_q, prog_addr_q}, {2'b10, 2'(p), 16'h1234});
    end
    msd_core_model_inst.prog(1'b1, 1'b1, 16'h0042);
    chk({prog_rd_q, prog_is_fetch_q, prog_addr_q}, {2'b11, 2'b01, 16'h0042});
    @(negedge clk_sys);
    chk(prog_rd_q, 32'h0000_0000);
  endtask

  task automatic t_move;
    wsfr(`MSD_ADDR_PAGE_SEL, `MSD_PAGE_SEL_RESET);
    msd_core_model_inst.move(1'b1, 1'b0, 16'h1FFF);
    chk({xram_sel_q, xram_wr_q, ext_sel_q, xram_addr_q}, {3'b110, 13'h1FFF});
    msd_core_model_inst.move(1'b0, 1'b0, 16'h2000);
    chk({xram_sel_q, ext_sel_q, ext_addr_q}, {2'b01, 16'h2000});
    wsfr(`MSD_ADDR_PAGE_SEL, 8'h00);
    msd_core_model_inst.move(1'b0, 1'b0, 16'h0010);
    chk({xram_sel_q, ext_sel_q, ext_addr_q}, {2'b01, 16'h0010});
    wsfr(`MSD_ADDR_PAGE_SEL, `MSD_PAGE_SEL_RESET);
  endtask

  task automatic t_ptr;
    wsfr(`MSD_ADDR_PTR_LOW, 8'h00);
    wsfr(`MSD_ADDR_PTR_HIGH, 8'h00);
    msd_core_model_inst.op(`MSD_OP_PTR_DEC);
    chk(data_pointer, 16'hFFFF);
    msd_core_model_inst.op(`MSD_OP_PTR_DEC);
    chk(data_pointer, 16'hFFFE);
    msd_core_model_inst.op(8'hA4);
    chk(data_pointer, 16'hFFFE);
    msd_core_model_inst.move(1'b0, 1'b1, 16'h0000);
    chk({xram_sel_q, ext_sel_q, ext_addr_q}, {2'b01, 16'hFFFE});
    wsfr(`MSD_ADDR_PTR_HIGH, 8'h10);
    msd_core_model_inst.move(1'b0, 1'b1, 16'hFFFF);
    chk({xram_sel_q, ext_sel_q, xram_addr_q}, {2'b10, 13'h10FE});
    rt(msd_pkg::MSD_ACC_DIRECT, `MSD_ADDR_PTR_HIGH, 2'h0, {4'b0100, 8'h83, 3'h0});
    chk({own_hit_q, own_rdata_q}, {1'b1, 8'h10});
    rt(msd_pkg::MSD_ACC_DIRECT, `MSD_ADDR_PTR_LOW, 2'h0, {4'b0100, 8'h82, 3'h0});
    chk({own_hit_q, own_rdata_q}, {1'b1, 8'hFE});
  endtask

  task automatic t_iram;
    rt(msd_pkg::MSD_ACC_DIRECT, 8'h30, 2'h0, {4'b1000, 8'h30, 3'h0});
    rt(msd_pkg::MSD_ACC_INDIRECT, 8'h90, 2'h0, {4'b1000, 8'h90, 3'h0});
    rt(msd_pkg::MSD_ACC_DIRECT, 8'h90, 2'h0, {4'b0100, 8'h90, 3'h0});
    for (int b = 0; b < 4; b++) begin
      rt(msd_pkg::MSD_ACC_WORK_REG, 8'h05, 2'(b), {4'b1000, 8'(b * 8 + 5), 3'h0});
    end
    rt(msd_pkg::MSD_ACC_BIT, 8'h13, 2'h0, {4'b1010, 8'h22, 3'h3});
    rt(msd_pkg::MSD_ACC_BIT, 8'h7F, 2'h0, {4'b1010, 8'h2F, 3'h7});
    rt(msd_pkg::MSD_ACC_BIT, 8'h8B, 2'h0, {4'b0110, 8'h88, 3'h3});
    rt(msd_pkg::MSD_ACC_BIT, 8'hE7, 2'h0, {4'b0110, 8'hE0, 3'h7});
    wsfr(`MSD_ADDR_PAGE_SEL, 8'h5B);
    chk(iram_route_q, {4'b0101, 8'h92, 3'h0});
    @(negedge clk_sys);
    chk(iram_route_q, 32'h0000_0000);
    rt(msd_pkg::MSD_ACC_DIRECT, `MSD_ADDR_PAGE_SEL, 2'h0, {4'b0100, 8'h92, 3'h0});
    chk({own_hit_q, own_rdata_q}, {1'b1, 8'h5B});
    rt(msd_pkg::MSD_ACC_INDIRECT, `MSD_ADDR_PAGE_SEL, 2'h0, {4'b1000, 8'h92, 3'h0});
    chk(own_hit_q, 32'h0000_0000);
    rt(msd_pkg::MSD_ACC_DIRECT, 8'h93, 2'h0, {4'b0100, 8'h93, 3'h0});
    chk({own_hit_q, own_rdata_q}, 32'h0000_0000);
  endtask

  // ========================================================================
  // clock, sequence and hang guard
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  initial begin
    num_errors = 0;
    samples_checked = 0;
    sys_rst = 1'b1;
    t_reset();
    t_fetch();
    t_table();
    t_move();
    t_ptr();
    t_iram();
    t_reset();
    tally_and_finish();
  end

  initial begin
    #100_000;
    num_errors++;
    $display("BAD %0t run did not finish", $time);
    tally_and_finish();
  end
endmodule // tb_memory_space_decoder
